//--- core/tsd_align.v
// tsd_align: one stream's input/output delay alignment and hi-z strobe timing
// What this block does
// - output frame starts on falling output clock edge while output frame pulse low.
// - output frames hold 32, 64 or 128 channels at 2, 4, 8 Mbps.
// - input channel delay in input delay bits 3-9, range by rate.
// - zero input channel delay puts channel 0 first after input boundary.
// - input bit delay 0-7 in bits 0-2; zero delay gives bit 7 first.
// - input sampled at 1/4..4/4 bit via control bits 3-4, default 3/4.
// - output channel delay in offset bits 5-11, range by rate, default zero.
// - output bit delay 0-7 bits from offset bits 2-4.
// - output fractional advance 0 to 3/4 bit from offset bits 0-1.
// - with no bit delay or advance, bit 7 of channel 0 leads.
// - hi-z strobe has one channel-long timeslot per output channel.
// - hi-z strobe works only with drive enable high, else high.
// - hi-z strobe held high all frame when output stream unused.
// - channel marked hi-z drives strobe high for exactly its timeslot.
// - hi-z strobe follows output timing including all programmed delays.
// - strobe advanced up to four steps, 15.2 ns or quarter bit.
// - master mode, zero advance: strobe and data share phase exactly.
// - bypass mode: no phase correction between strobe and data.
// - channel delays add buffering to throughput; bit offsets do not.
// - enabled channel delay counts 1-31, 1-63 or 1-127 by rate.
// - input frame starts on falling input clock edge while frame pulse low.
// - no channel delays: throughput is two frames plus channel difference.
// - input delay makes it three frames minus delay; output delay adds.
`include "tsd_regs.vh"
module tsd_align (
   input wire sys_clk, // 40 MHz system clock
   input wire reset, // synchronous reset, active high
   input wire in_serial_clock, // input clock pin, twice the 8 Mbps rate
   input wire in_frame_pulse, // input frame pulse pin, active low
   input wire serial_data_in, // serial data input pin
   input wire out_serial_clock, // output clock from the timing pll
   input wire out_frame_pulse, // output frame pulse, active low
   input wire output_drive_enable_pin, // hi-z strobes enabled while high
   input wire cpu_req, // one-cycle register access request
   input wire cpu_wr, // 1 write, 0 read
   input wire [11:0] cpu_addr, // register word address
   input wire [15:0] cpu_wdata, // write data
   output reg [15:0] cpu_rdata, // read data, valid with cpu_ack
   output reg cpu_ack, // one-cycle answer pulse
   output reg serial_data_out, // serial data output
   output reg hiz_control_strobe, // high marks a hi-z timeslot
   output wire rx_valid, // received byte available
   input wire rx_ready, // receiver takes the byte
   output wire [7:0] rx_data, // received byte
   output wire [6:0] rx_chan // channel of the received byte
);
   reg [15:0] in_delay_q;
   reg [15:0] in_ctrl_q;
   reg [15:0] out_offset_q;
   reg [15:0] out_ctrl_q;
   reg [127:0] hiz_map_q;
   reg ovf_q;
   reg [2:0] ick_s1, ick_s2, ick_s3;
   reg [1:0] ifp_s, idat_s;
   reg [2:0] ock_s1;
   reg [1:0] ock_s2;
   reg ock_s3;
   reg [1:0] ofp_s, ode_s;
   reg [11:0] icnt_q;
   reg [11:0] ocnt_q;
   reg [7:0] ishift_q;
   reg rx_push_q;
   reg [14:0] rx_word_q;
   reg cpu_rd_mem_q;
   reg [15:0] cpu_rd_mux;
   reg [3:0] opipe_q;
   reg [6:0] cpu_mem_idx_q;

   wire buf_in_ready;
   wire [7:0] mem_a_q;
   wire [7:0] mem_b_q;

   // stream's own rate: quarter bit = 1 << sh edges of the 2x clock
   function [1:0] f_sh;
      input [2:0] rate;
      begin
         case (rate)
            `TSD_RATE_8M: f_sh = 2'h0;
            `TSD_RATE_4M: f_sh = 2'h1;
            default: f_sh = 2'h2;
         endcase
      end
   endfunction

   // channel and bit delay as clock edges
   function [11:0] f_dly;
      input [6:0] cd;
      input [2:0] bd;
      input [1:0] sh;
      begin
         f_dly = {cd, bd, 2'b00} << sh;
      end
   endfunction

   // quarter-bit count as clock edges
   function [11:0] f_qtr;
      input [2:0] q;
      input [1:0] sh;
      begin
         f_qtr = {9'h000, q} << sh;
      end
   endfunction

   // edge index inside the current bit
   function [4:0] f_sub;
      input [11:0] pos;
      input [1:0] sh;
      begin
         case (sh)
            2'h0: f_sub = {3'h0, pos[1:0]};
            2'h1: f_sub = {2'h0, pos[2:0]};
            default: f_sub = {1'b0, pos[3:0]};
         endcase
      end
   endfunction

   // bit counter from frame start: [9:3] channel, [2:0] bit slot
   function [9:0] f_slot;
      input [11:0] pos;
      input [1:0] sh;
      reg [11:0] t;
      begin
         t = pos >> sh;
         f_slot = t[11:2];
      end
   endfunction

   // field views
   wire [2:0] in_rate = in_ctrl_q[`TSD_IC_RATE_MSB:`TSD_IC_RATE_LSB];
   wire [1:0] in_samp = in_ctrl_q[`TSD_IC_SAMP_MSB:`TSD_IC_SAMP_LSB];
   wire [6:0] in_cd = in_delay_q[`TSD_ID_CHAN_MSB:`TSD_ID_CHAN_LSB];
   wire [2:0] in_bd = in_delay_q[`TSD_ID_BIT_MSB:`TSD_ID_BIT_LSB];
   wire [2:0] out_rate = out_ctrl_q[`TSD_OC_RATE_MSB:`TSD_OC_RATE_LSB];
   wire [2:0] hadv_raw = out_ctrl_q[`TSD_OC_HADV_MSB:`TSD_OC_HADV_LSB];
   wire hstep_qtr = out_ctrl_q[`TSD_OC_HSTEP_BIT];
   wire [6:0] out_cd = out_offset_q[`TSD_OO_CHAN_MSB:`TSD_OO_CHAN_LSB];
   wire [2:0] out_bd = out_offset_q[`TSD_OO_BIT_MSB:`TSD_OO_BIT_LSB];
   wire [1:0] out_frac = out_offset_q[`TSD_OO_FRAC_MSB:`TSD_OO_FRAC_LSB];
   wire [1:0] ish = f_sh(in_rate);
   wire [1:0] osh = f_sh(out_rate);

   // pin synchronisers; stage 1 feeds stage 2 only
   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         ick_s1 <= 3'h7;
         ick_s2 <= 3'h7;
         ick_s3 <= 3'h7;
         ifp_s <= 2'h3;
         idat_s <= 2'h0;
         ock_s1 <= 3'h7;
         ock_s2 <= 2'h3;
         ock_s3 <= 1'b1;
         ofp_s <= 2'h3;
         ode_s <= 2'h0;
      end
      else
      begin
         ick_s1 <= {ick_s1[1:0], in_serial_clock};
         ick_s2 <= {ick_s2[1:0], ick_s1[1]};
         ick_s3 <= ick_s2;
         ifp_s <= {ifp_s[0], in_frame_pulse};
         idat_s <= {idat_s[0], serial_data_in};
         ock_s1 <= {ock_s1[1:0], out_serial_clock};
         ock_s2 <= {ock_s2[0], ock_s1[1]};
         ock_s3 <= ock_s2[1];
         ofp_s <= {ofp_s[0], out_frame_pulse};
         ode_s <= {ode_s[0], output_drive_enable_pin};
      end
   end

   wire ick = ick_s2[0];
   wire ick_d = ick_s3[0];
   wire ock = ock_s2[1];
   wire i_edge = ick != ick_d;
   wire o_edge = ock != ock_s3;
   wire i_bound = ick_d && !ick && !ifp_s[1];
   wire o_bound = ock_s3 && !ock && !ofp_s[1];

   // edge counters; a 4096-edge frame is 125 us at every rate
   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         icnt_q <= 12'h000;
         ocnt_q <= 12'h000;
      end
      else
      begin
         if (i_bound)
            icnt_q <= 12'h000;
         else if (i_edge)
            icnt_q <= icnt_q + 12'h001;
         if (o_bound)
            ocnt_q <= 12'h000;
         else if (o_edge)
            ocnt_q <= ocnt_q + 12'h001;
      end
   end

   // input side: shift own boundary back by the delay in own bit periods
   wire [11:0] ipos = icnt_q - f_dly(in_cd, in_bd, ish);
   wire [9:0] islot = f_slot(ipos, ish);
   wire [4:0] isub = f_sub(ipos, ish);
   wire [4:0] isamp_at = (({3'h0, in_samp} + 5'h01) << ish) - 5'h01;
   wire i_sample = (i_edge || i_bound) && (isub == isamp_at) && (in_rate != `TSD_RATE_OFF);

   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         ishift_q <= 8'h00;
         rx_push_q <= 1'b0;
         rx_word_q <= 15'h0000;
         ovf_q <= 1'b0;
      end
      else
      begin
         rx_push_q <= 1'b0;
         if (i_sample)
         begin
            ishift_q <= {ishift_q[6:0], idat_s[1]}; // bit 7 first
            if (islot[2:0] == 3'h7)
            begin
               rx_push_q <= 1'b1;
               rx_word_q <= {islot[9:3], ishift_q[6:0], idat_s[1]};
            end
         end
         // a full buffer drops the byte; the set wins over a clear
         if (rx_push_q && !buf_in_ready)
            ovf_q <= 1'b1;
         else if (cpu_req && cpu_wr && cpu_addr == `TSD_ADDR_STATUS
                  && cpu_wdata[`TSD_ST_OVF_BIT])
            ovf_q <= 1'b0;
      end
   end

   tsd_buf2 #(
      .WIDTH(15)
   ) u_rx_buf (
      .sys_clk(sys_clk),
      .reset(reset),
      .in_valid(rx_push_q),
      .in_ready(buf_in_ready),
      .in_data(rx_word_q),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data({rx_chan, rx_data})
   );

   // output side: delay then advance, all in own quarter bits
   wire [11:0] odly = f_dly(out_cd, out_bd, osh);
   wire [11:0] opos = ocnt_q - odly + f_qtr({1'b0, out_frac}, osh);
   wire [9:0] oslot = f_slot(opos, osh);
   // strobe advance: quarter-bit steps, or 15.2 ns steps counted in 8 Mbps edges
   wire [2:0] hsteps = (hadv_raw > `TSD_HIZ_STEP_MAX) ? `TSD_HIZ_STEP_MAX : hadv_raw;
   wire [31:0] hadv_ns = hsteps / `TSD_HIZ_NS_STEPS_PER_EDGE;
   wire [11:0] hadv = hstep_qtr ? f_qtr(hsteps, osh) : hadv_ns[11:0];
   wire [11:0] hpos = opos + hadv;
   wire [9:0] hslot = f_slot(hpos, osh);

   tsd_chan_mem u_chan_mem (
      .sys_clk(sys_clk),
      .wr_en(cpu_req && cpu_wr && (cpu_addr & `TSD_ADDR_CHAN_MASK) == `TSD_ADDR_CHAN_BASE),
      .wr_addr(cpu_addr[6:0]),
      .wr_data(cpu_wdata[7:0]),
      .rd_a_addr(oslot[9:3]),
      .rd_a_data(mem_a_q),
      .rd_b_addr(cpu_addr[6:0]),
      .rd_b_data(mem_b_q)
   );

   // bit index and hi-z flag wait for the memory read, so data and strobe never drift apart
   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         opipe_q <= 4'hf;
         serial_data_out <= 1'b1;
         hiz_control_strobe <= 1'b1;
      end
      else
      begin
         opipe_q <= {hiz_map_q[hslot[9:3]], ~oslot[2:0]};
         serial_data_out <= mem_a_q[opipe_q[2:0]];
         if (!ode_s[1])
            hiz_control_strobe <= 1'b1;
         else if (out_rate == `TSD_RATE_OFF)
            hiz_control_strobe <= 1'b1;
         else
            hiz_control_strobe <= opipe_q[3];
      end
   end

   // throughput frames: extra buffer frame when input channel delay is in use
   wire [2:0] tput_frames = (in_cd != 7'h00) ? `TSD_TPUT_ICD_FRAMES
                                             : `TSD_TPUT_BASE_FRAMES;

   // cpu register port
   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         in_delay_q <= `TSD_ID_RESET;
         in_ctrl_q <= `TSD_IC_RESET;
         out_offset_q <= `TSD_OO_RESET;
         out_ctrl_q <= `TSD_OC_RESET;
         hiz_map_q <= 128'h0;
         cpu_ack <= 1'b0;
         cpu_rdata <= 16'h0000;
         cpu_rd_mem_q <= 1'b0;
         cpu_mem_idx_q <= 7'h00;
      end
      else
      begin
         cpu_ack <= 1'b0;
         cpu_rd_mem_q <= 1'b0;
         if (cpu_rd_mem_q)
         begin
            cpu_ack <= 1'b1;
            cpu_rdata <= {7'h00, hiz_map_q[cpu_mem_idx_q], mem_b_q};
         end
         else if (cpu_req)
         begin
            if ((cpu_addr & `TSD_ADDR_CHAN_MASK) == `TSD_ADDR_CHAN_BASE && !cpu_wr)
            begin
               cpu_rd_mem_q <= 1'b1;
               cpu_mem_idx_q <= cpu_addr[6:0];
            end
            else
            begin
               cpu_ack <= 1'b1;
               cpu_rdata <= cpu_rd_mux;
            end
            if (cpu_wr)
            begin
               case (cpu_addr)
                  `TSD_ADDR_IN_DELAY: in_delay_q <= {6'h00, cpu_wdata[9:0]};
                  `TSD_ADDR_IN_CTRL: in_ctrl_q <= {11'h000, cpu_wdata[4:0]};
                  `TSD_ADDR_OUT_OFFSET: out_offset_q <= {4'h0, cpu_wdata[11:0]};
                  `TSD_ADDR_OUT_CTRL: out_ctrl_q <= {9'h000, cpu_wdata[6:0]};
                  default:
                  begin
                     if ((cpu_addr & `TSD_ADDR_CHAN_MASK) == `TSD_ADDR_CHAN_BASE)
                        hiz_map_q[cpu_addr[6:0]] <= cpu_wdata[8];
                  end
               endcase
            end
         end
      end
   end

   // register read mux, unmapped reads give zero
   always @*
   begin
      case (cpu_addr)
         `TSD_ADDR_IN_DELAY: cpu_rd_mux = in_delay_q;
         `TSD_ADDR_IN_CTRL: cpu_rd_mux = in_ctrl_q;
         `TSD_ADDR_OUT_OFFSET: cpu_rd_mux = out_offset_q;
         `TSD_ADDR_OUT_CTRL: cpu_rd_mux = out_ctrl_q;
         `TSD_ADDR_STATUS: cpu_rd_mux = {12'h000, tput_frames, ovf_q};
         default: cpu_rd_mux = 16'h0000;
      endcase
   end
endmodule // tsd_align

//--- core/tsd_regs.vh
// tsd_regs.vh: register offsets, field positions, reset values and timing counts
`ifndef TSD_REGS_VH
`define TSD_REGS_VH

// register indices on the cpu port (12-bit word address)
`define TSD_ADDR_IN_DELAY 12'h000
`define TSD_ADDR_IN_CTRL 12'h001
`define TSD_ADDR_OUT_OFFSET 12'h002
`define TSD_ADDR_OUT_CTRL 12'h003
`define TSD_ADDR_STATUS 12'h004
`define TSD_ADDR_CHAN_BASE 12'h080
`define TSD_ADDR_CHAN_MASK 12'hf80

// stream_input_delay fields
`define TSD_ID_BIT_LSB 0
`define TSD_ID_BIT_MSB 2
`define TSD_ID_CHAN_LSB 3
`define TSD_ID_CHAN_MSB 9
`define TSD_ID_RESET 16'h0000

// stream_input_control fields
`define TSD_IC_RATE_LSB 0
`define TSD_IC_RATE_MSB 2
`define TSD_IC_SAMP_LSB 3
`define TSD_IC_SAMP_MSB 4
`define TSD_IC_RESET 16'h0013

// stream_output_offset fields
`define TSD_OO_FRAC_LSB 0
`define TSD_OO_FRAC_MSB 1
`define TSD_OO_BIT_LSB 2
`define TSD_OO_BIT_MSB 4
`define TSD_OO_CHAN_LSB 5
`define TSD_OO_CHAN_MSB 11
`define TSD_OO_RESET 16'h0000

// stream_output_control fields
`define TSD_OC_RATE_LSB 0
`define TSD_OC_RATE_MSB 2
`define TSD_OC_HADV_LSB 3
`define TSD_OC_HADV_MSB 5
`define TSD_OC_HSTEP_BIT 6
`define TSD_OC_RESET 16'h0003

// status fields
`define TSD_ST_OVF_BIT 0
`define TSD_ST_TPUT_LSB 1
`define TSD_ST_TPUT_MSB 3

// rate codes
`define TSD_RATE_OFF 3'h0
`define TSD_RATE_2M 3'h1
`define TSD_RATE_4M 3'h2
`define TSD_RATE_8M 3'h3

// timing
`define TSD_HIZ_STEP_MAX 3'h4
`define TSD_HIZ_STEP_PS 15200
`define TSD_EDGE_PS 30500
`define TSD_HIZ_NS_STEPS_PER_EDGE (`TSD_EDGE_PS / `TSD_HIZ_STEP_PS)
`define TSD_TPUT_BASE_FRAMES 3'h2
`define TSD_TPUT_ICD_FRAMES 3'h3

`endif

//--- core/tsd_chan_mem.v
// tsd_chan_mem: 128 x 8 outgoing channel byte memory with registered reads
module tsd_chan_mem (
   input wire sys_clk, // system clock
   input wire wr_en, // write strobe
   input wire [6:0] wr_addr, // write channel
   input wire [7:0] wr_data, // write byte
   input wire [6:0] rd_a_addr, // serialiser read channel
   output reg [7:0] rd_a_data, // serialiser read byte
   input wire [6:0] rd_b_addr, // cpu read channel
   output reg [7:0] rd_b_data // cpu read byte
);
   reg [7:0] mem [0:127];

   always @(posedge sys_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
   end
endmodule // tsd_chan_mem

//--- core/tsd_buf2.v
// tsd_buf2: two-entry valid/ready buffer with registered outputs
module tsd_buf2 #(
   parameter WIDTH = 15
) (
   input wire sys_clk, // system clock
   input wire reset, // synchronous, active high
   input wire in_valid, // word offered
   output reg in_ready, // room for a word
   input wire [WIDTH-1:0] in_data, // offered word
   output reg out_valid, // head word valid
   input wire out_ready, // consumer takes head
   output reg [WIDTH-1:0] out_data // head word
);
   reg [WIDTH-1:0] spare_q;
   reg spare_valid_q;
   wire push;
   wire pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         out_valid <= 1'b0;
         spare_valid_q <= 1'b0;
         in_ready <= 1'b1;
         out_data <= {WIDTH{1'b0}};
         spare_q <= {WIDTH{1'b0}};
      end
      else
      begin
         if (pop)
         begin
            if (spare_valid_q)
            begin
               out_data <= spare_q;
               out_valid <= 1'b1;
               spare_valid_q <= push;
               spare_q <= in_data;
            end
            else
            begin
               out_valid <= push;
               out_data <= in_data;
            end
            in_ready <= 1'b1;
         end
         else if (push)
         begin
            if (!out_valid)
            begin
               out_valid <= 1'b1;
               out_data <= in_data;
            end
            else
            begin
               spare_valid_q <= 1'b1;
               spare_q <= in_data;
               in_ready <= 1'b0;
            end
         end
      end
   end
endmodule // tsd_buf2

//--- sim/tsd_align_monitor.sv
// assertion checker for the stream alignment block, bound to its ports
module tsd_align_monitor (
   input wire sys_clk, // system clock
   input wire reset, // synchronous, active high
   input wire output_drive_enable_pin, // strobe enable pin
   input wire cpu_req, // access request
   input wire cpu_wr, // write select
   input wire [11:0] cpu_addr, // word address
   input wire [15:0] cpu_wdata, // write data
   input wire [15:0] cpu_rdata, // read data
   input wire cpu_ack, // access answer
   input wire serial_data_out, // serial output
   input wire hiz_control_strobe, // hi-z strobe
   input wire rx_valid, // byte offered
   input wire rx_ready, // byte taken
   input wire [7:0] rx_data, // received byte
   input wire [6:0] rx_chan // its channel
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic [15:0] id_q, ic_q, oo_q, oc_q, exp_q;
   // shadow copies, so reads are judged against what software wrote
   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         id_q <= 16'h0000;
         ic_q <= 16'h0013;
         oo_q <= 16'h0000;
         oc_q <= 16'h0003;
      end
      else if (cpu_req && cpu_wr)
         case (cpu_addr)
            12'h000: id_q <= cpu_wdata & 16'h03ff;
            12'h001: ic_q <= cpu_wdata & 16'h001f;
            12'h002: oo_q <= cpu_wdata & 16'h0fff;
            12'h003: oc_q <= cpu_wdata & 16'h007f;
            default: ;
         endcase
   end
   always @(posedge sys_clk)
      case (cpu_addr[1:0])
         2'h0: exp_q <= id_q;
         2'h1: exp_q <= ic_q;
         2'h2: exp_q <= oo_q;
         default: exp_q <= oc_q;
      endcase
   sequence s_reg_req;
      cpu_req && (cpu_wr || cpu_addr[11:7] != 5'h01);
   endsequence
   sequence s_mem_rd;
      cpu_req && !cpu_wr && cpu_addr[11:7] == 5'h01;
   endsequence
   property p_reg_ack;
      s_reg_req |=> cpu_ack;
   endproperty
   a_reg_ack: assert property (p_reg_ack)
      else $error("register access not answered");
   property p_mem_ack;
      s_mem_rd |=> !cpu_ack ##1 cpu_ack;
   endproperty
   a_mem_ack: assert property (p_mem_ack)
      else $error("memory read answer timing wrong");
   property p_rd;
      cpu_req && !cpu_wr && cpu_addr < 12'h004 |=> cpu_rdata == exp_q;
   endproperty
   a_rd: assert property (p_rd)
      else $error("register read value wrong");
   property p_unmapped;
      s_reg_req ##0 (!cpu_wr && cpu_addr > 12'h004) |=> cpu_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_odp;
      !output_drive_enable_pin [*5] |-> hiz_control_strobe;
   endproperty
   a_odp: assert property (p_odp)
      else $error("strobe low while drive enable low");
   property p_off;
      oc_q[2:0] == 3'h0 [*8] |-> hiz_control_strobe;
   endproperty
   a_off: assert property (p_off)
      else $error("strobe low on unused stream");
   property p_reset;
      disable iff (1'b0)
      reset |=> hiz_control_strobe && serial_data_out && !cpu_ack && !rx_valid
         && cpu_rdata == 16'h0000;
   endproperty
   a_reset: assert property (p_reset)
      else $error("outputs wrong in reset");
   property p_rx_hold;
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data) && $stable(rx_chan);
   endproperty
   a_rx_hold: assert property (p_rx_hold)
      else $error("received word lost while stalled");
endmodule // tsd_align_monitor
bind tsd_align tsd_align_monitor mon_u (.sys_clk, .reset, .output_drive_enable_pin, .cpu_req,
   .cpu_wr, .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_ack, .serial_data_out, .hiz_control_strobe,
   .rx_valid, .rx_ready, .rx_data, .rx_chan);

//--- sim/tsd_far_end.sv
// far-end tdm device: free-running link clock, frame pulse and input stream
module tsd_far_end (
   output logic lclk, // link clock, 200 ns period
   output logic fp_n, // frame pulse, active low
   output logic sdat // serial data towards the block
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt;
   initial
   begin
      lclk = 1'b0;
      fp_n = 1'b1;
      sdat = 1'b1;
      cnt = 0;
      forever
      begin
         #100 lclk = ~lclk;
         cnt = (cnt + 1) % 4096;
         // low across the one falling edge that opens the frame
         fp_n = !(cnt == 4095 || cnt == 0);
         // four link edges a bit, 128 channels, msb first
         if (cnt % 4 == 0)
            sdat = 1'(8'((cnt / 32 % 16) * 17 ^ 8'h90) >> (7 - cnt / 4 % 8));
      end
   end
endmodule // tsd_far_end

//--- sim/testbench.sv
// self-checking bench for the stream alignment block
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic lclk, fp_n, sdat, cpu_ack, sdo, hiz, rx_valid;
   logic odp = 1'b1;
   logic rx_ready = 1'b1;
   logic cpu_req = 1'b0;
   logic cpu_wr = 1'b0;
   logic [11:0] cpu_addr = 12'h000;
   logic [15:0] cpu_wdata = 16'h0000;
   logic [15:0] cpu_rdata, rd;
   logic [7:0] rx_data;
   logic [6:0] rx_chan;
   logic [15:0] rst_v [4] = '{16'h0000, 16'h0013, 16'h0000, 16'h0003};
   logic [15:0] msk_v [4] = '{16'h03ff, 16'h001f, 16'h0fff, 16'h007f};
   int n_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   always #12.5 sys_clk = ~sys_clk;
   tsd_far_end far_u (.lclk(lclk), .fp_n(fp_n), .sdat(sdat));
   tsd_align dut_u (.sys_clk(sys_clk), .reset(reset), .in_serial_clock(lclk),
      .in_frame_pulse(fp_n), .serial_data_in(sdat), .out_serial_clock(lclk),
      .out_frame_pulse(fp_n), .output_drive_enable_pin(odp), .cpu_req(cpu_req),
      .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .cpu_ack(cpu_ack), .serial_data_out(sdo), .hiz_control_strobe(hiz),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_chan(rx_chan));
   function automatic logic [7:0] pb(input int c);
      return 8'((c % 16) * 17 ^ 8'h90);
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   // one-cycle request pulse, then wait for the answer a bounded time
   task automatic cpu(input logic wr, input logic [11:0] a, input logic [15:0] wd);
      int n;
      n = 0;
      @(negedge sys_clk);
      cpu_req = 1'b1;
      cpu_wr = wr;
      cpu_addr = a;
      cpu_wdata = wd;
      @(negedge sys_clk);
      cpu_req = 1'b0;
      while (cpu_ack !== 1'b1 && n < 8)
      begin
         @(negedge sys_clk);
         n++;
      end
      chk(n < 8, 1);
      rd = cpu_rdata;
   endtask
   task automatic frame_start();
      int n;
      n = 0;
      do
      begin
         @(negedge lclk);
         n++;
      end
      while (fp_n !== 1'b0 && n < 3000);
   endtask
   // waits link edges, then lets the synchroniser latency settle
   task automatic edges(input int n);
      repeat (n) @(lclk);
      #50;
   endtask
   task automatic rx_wait(input int c);
      int n;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (!(rx_valid === 1'b1 && rx_chan === 7'(c)) && n < 20000);
      chk(rx_chan, 7'(c));
   endtask
   task automatic hiz_hi();
      for (int i = 0; i < 8; i++)
      begin
         repeat (97) @(negedge sys_clk);
         chk(hiz, 1);
      end
   endtask
   task automatic conclude();
      $display("mismatches %0d, checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_errors++;
         conclude();
      end
   end
   initial
   begin
      repeat (8) @(negedge sys_clk);
      reset = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         cpu(0, 12'(i), 0);
         chk(rd, rst_v[i]);
         cpu(1, 12'(i), 16'hffff);
         cpu(0, 12'(i), 0);
         chk(rd, msk_v[i]);
         cpu(1, 12'(i), rst_v[i]);
      end
      cpu(1, 12'h010, 16'hffff);
      cpu(0, 12'h010, 0);
      chk(rd, 0);
      cpu(0, 12'h004, 0);
      chk(rd[3:1], 3'h2);
      for (int c = 0; c < 4; c++)
         cpu(1, 12'h080 + 12'(c), c == 0 ? 16'h00a5 : (c == 2 ? 16'h0100 : 16'h0000));
      cpu(0, 12'h082, 0);
      chk(rd, 16'h0100);
      odp = 1'b0;
      hiz_hi();
      odp = 1'b1;
      cpu(1, 12'h003, 16'h0000);
      hiz_hi();
      cpu(1, 12'h003, 16'h0003);
      // stall the receiver until the two-entry buffer must refuse
      rx_ready = 1'b0;
      repeat (700) @(negedge sys_clk);
      chk(rx_valid, 1);
      cpu(0, 12'h004, 0);
      chk(rd[0], 1);
      rx_ready = 1'b1;
      repeat (4) @(negedge sys_clk);
      cpu(1, 12'h004, 16'h0001);
      cpu(0, 12'h004, 0);
      chk(rd[0], 0);
      frame_start();
      for (int b = 0; b < 8; b++)
      begin
         edges(b == 0 ? 2 : 4);
         chk(sdo, 16'(8'ha5 >> (7 - b)) & 16'h0001);
      end
      edges(18);
      chk(hiz, 0);
      edges(32);
      chk(hiz, 1);
      edges(32);
      chk(hiz, 0);
      rx_wait(4);
      chk(rx_data, pb(4));
      cpu(1, 12'h000, 16'h0008);
      cpu(0, 12'h004, 0);
      chk(rd[3:1], 3'h3);
      rx_wait(8);
      chk(rx_data, pb(9));
      cpu(1, 12'h000, 16'h0001);
      cpu(0, 12'h004, 0);
      chk(rd[3:1], 3'h2);
      rx_wait(12);
      chk(rx_data, 8'({pb(12), pb(13)} >> 7));
      cpu(1, 12'h002, 16'h0020);
      // strobe advanced by four quarter-bit steps, one whole bit ahead of the data
      cpu(1, 12'h003, 16'h0063);
      frame_start();
      edges(80);
      chk(hiz, 0);
      edges(32);
      chk(hiz, 1);
      edges(14);
      chk(hiz, 0);
      conclude();
   end
endmodule // testbench
